/* File: hdl/gpc_pad_ctrl.sv */
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Operation
// - Direction bit 1 output, 0 input
// - Route bit picks peripheral or software drive
// - Software mode drives the drive value bit
// - Input mode: drive bit selects pull-up
// - Group A analog disable blocks digital input
// - Pad level change can raise interrupt
// - Change interrupt only when its enable set
// - Readback bit shows current pad level
// - Readback read clears pending change interrupt only while a change enable of the group is set
// - Reset returns all registers to defaults
module gpc_pad_ctrl
    import gpc_pkg::*;
#(
    parameter int PAD_W = GPC_PAD_W
)
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Register port
    input wire logic [GPC_ADDR_W-1:0] i_addr,
    input wire logic [GPC_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [GPC_DATA_W-1:0] o_rdata,
    // Pads, group A in the low bits, then B, then C
    input wire logic [3*PAD_W-1:0] i_pad_in,
    output logic [3*PAD_W-1:0] o_pad_out,
    output logic [3*PAD_W-1:0] o_pad_oe,
    output logic [3*PAD_W-1:0] o_pad_pullup,
    output logic [PAD_W-1:0] o_pad_a_input_en,
    // Peripheral outputs offered to the pads
    input wire logic [3*PAD_W-1:0] i_periph_out,
    // Level interrupt
    output logic o_irq
);

    // Configuration registers, one word per group; the analog disable word is for group A only
    logic [PAD_W-1:0] dir_reg [GPC_GROUPS];
    logic [PAD_W-1:0] route_reg [GPC_GROUPS];
    logic [PAD_W-1:0] drive_reg [GPC_GROUPS];
    logic [PAD_W-1:0] chg_en_reg [GPC_GROUPS];
    logic [PAD_W-1:0] analog_reg;
    // Interrupt status and enable, one bit per group
    logic [GPC_GROUPS-1:0] sts_reg;
    logic [GPC_GROUPS-1:0] sts_next;
    logic [GPC_GROUPS-1:0] irq_en_reg;
    // Read data register
    logic [GPC_DATA_W-1:0] rdata_reg;
    logic [GPC_DATA_W-1:0] rdata_next;

    // Synchronised pads and per group results
    wire [3*PAD_W-1:0] pad_sync;
    wire [3*PAD_W-1:0] level;
    wire [3*PAD_W-1:0] change;
    wire [GPC_GROUPS-1:0] grp_evt;
    wire [GPC_GROUPS-1:0] rb_clr;
    wire [GPC_GROUPS-1:0] sw_clr;

    // Address split: window select and offset inside it
    wire [2:0] win = i_addr[7:5];
    wire [4:0] ofs = i_addr[4:0];
    wire irq_win = (win == GPC_IRQ_BASE[7:5]);
    wire wr_irq_en = i_wr && irq_win && (ofs == GPC_IRQ_EN_OFS);
    wire wr_irq_clr = i_wr && irq_win && (ofs == GPC_IRQ_CLR_OFS);

    // Window base of group g
    function automatic logic [2:0] grp_win(input int g);
        logic [7:0] base;
        base = GPC_GRP_A_BASE;
        if (g == 1)
            base = GPC_GRP_B_BASE;
        else if (g == 2)
            base = GPC_GRP_C_BASE;
        return base[7:5];
    endfunction

    // Strobe hit on one register of group g
    function automatic logic grp_hit(input int g, input logic [4:0] o);
        return (win == grp_win(g)) && (ofs == o);
    endfunction

    // Pads cross into the core clock before anything reads them
    gpc_sync #(
        .WIDTH(3*PAD_W)
    ) u_sync (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_async(i_pad_in),
        .o_sync(pad_sync)
    );

    // One pad group instance per group, registers written per group
    for (genvar g = 0; g < GPC_GROUPS; g++)
    begin : g_grp
        wire [PAD_W-1:0] in_dis;
        // Only group A has an analog input disable
        assign in_dis = (g == 0) ? analog_reg : '0;

        gpc_pad_group #(
            .PAD_W(PAD_W)
        ) u_grp (
            .i_core_clk(i_core_clk),
            .i_rstn(i_rstn),
            .i_pad_sync(pad_sync[g*PAD_W +: PAD_W]),
            .i_dir(dir_reg[g]),
            .i_route(route_reg[g]),
            .i_drive(drive_reg[g]),
            .i_in_dis(in_dis),
            .i_periph(i_periph_out[g*PAD_W +: PAD_W]),
            .o_pad_out(o_pad_out[g*PAD_W +: PAD_W]),
            .o_pad_oe(o_pad_oe[g*PAD_W +: PAD_W]),
            .o_pullup(o_pad_pullup[g*PAD_W +: PAD_W]),
            .o_level(level[g*PAD_W +: PAD_W]),
            .o_change(change[g*PAD_W +: PAD_W])
        );

        // Only enabled pads may flag a change
        assign grp_evt[g] = |(change[g*PAD_W +: PAD_W] & chg_en_reg[g]);
        // Readback read drops the pending flag when changes are enabled
        assign rb_clr[g] = i_rd && grp_hit(g, GPC_READBACK_OFS)
            && (|chg_en_reg[g]);
        assign sw_clr[g] = wr_irq_clr && i_wdata[g];

        // Group configuration; every register returns to default
        always_ff @(posedge i_core_clk)
        begin
            if (!i_rstn)
            begin
                dir_reg[g] <= PAD_W'(GPC_RST_VAL);
                route_reg[g] <= PAD_W'(GPC_RST_VAL);
                drive_reg[g] <= PAD_W'(GPC_RST_VAL);
                chg_en_reg[g] <= PAD_W'(GPC_RST_VAL);
            end
            else if (i_wr)
            begin
                if (grp_hit(g, GPC_DIR_OFS))
                    dir_reg[g] <= i_wdata[PAD_W-1:0];
                if (grp_hit(g, GPC_ROUTE_OFS))
                    route_reg[g] <= i_wdata[PAD_W-1:0];
                if (grp_hit(g, GPC_DRIVE_OFS))
                    drive_reg[g] <= i_wdata[PAD_W-1:0];
                if (grp_hit(g, GPC_CHG_EN_OFS))
                    chg_en_reg[g] <= i_wdata[PAD_W-1:0];
            end
        end
    end

    // Group A input enable seen by the pad cells
    assign o_pad_a_input_en = ~analog_reg;

    // Analog disable register of group A
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
            analog_reg <= PAD_W'(GPC_RST_VAL);
        else if (i_wr && grp_hit(0, GPC_ANALOG_OFS))
            analog_reg <= i_wdata[PAD_W-1:0];
    end

    // Sticky status: a new event beats any clear in the same cycle
    assign sts_next = (sts_reg & ~(rb_clr | sw_clr)) | grp_evt;

    // Status and interrupt enable
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
        begin
            sts_reg <= '0;
            irq_en_reg <= '0;
        end
        else
        begin
            sts_reg <= sts_next;
            if (wr_irq_en)
                irq_en_reg <= i_wdata[GPC_GROUPS-1:0];
        end
    end

    // Interrupt is a level while an enabled flag stands
    assign o_irq = |(sts_reg & irq_en_reg);

    // Read mux; unmapped and write-only registers read as zero
    always_comb
    begin
        rdata_next = '0;
        for (int g = 0; g < GPC_GROUPS; g++)
        begin
            if (grp_hit(g, GPC_DIR_OFS))
                rdata_next[PAD_W-1:0] = dir_reg[g];
            else if (grp_hit(g, GPC_ROUTE_OFS))
                rdata_next[PAD_W-1:0] = route_reg[g];
            else if (grp_hit(g, GPC_DRIVE_OFS))
                rdata_next[PAD_W-1:0] = drive_reg[g];
            else if (grp_hit(g, GPC_CHG_EN_OFS))
                rdata_next[PAD_W-1:0] = chg_en_reg[g];
            else if (grp_hit(g, GPC_READBACK_OFS))
                rdata_next[PAD_W-1:0] = level[g*PAD_W +: PAD_W];
        end
        if (grp_hit(0, GPC_ANALOG_OFS))
            rdata_next[PAD_W-1:0] = analog_reg;
        if (irq_win && (ofs == GPC_IRQ_STS_OFS))
            rdata_next[GPC_GROUPS-1:0] = sts_reg;
        if (irq_win && (ofs == GPC_IRQ_EN_OFS))
            rdata_next[GPC_GROUPS-1:0] = irq_en_reg;
    end

    // Read data stand only in the cycle after the read strobe
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
            rdata_reg <= '0;
        else if (i_rd)
            rdata_reg <= rdata_next;
        else
            rdata_reg <= '0;
    end

    assign o_rdata = rdata_reg;

    // Checks
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);

    // Group A offsets used by the checks
    wire hit_dir_a = grp_hit(0, GPC_DIR_OFS);
    wire hit_rb_a = grp_hit(0, GPC_READBACK_OFS);

    dir_to_oe_a: assert property (
        i_wr && hit_dir_a |-> ##2
        o_pad_oe[PAD_W-1:0] == $past(i_wdata[PAD_W-1:0], 2))
        else $error("direction write not seen on output enable");

    route_mux_a: assert property (
        ##1 o_pad_out == (($past(i_periph_out) & $past({route_reg[2],
        route_reg[1], route_reg[0]})) | (~$past({route_reg[2],
        route_reg[1], route_reg[0]}) & $past({drive_reg[2],
        drive_reg[1], drive_reg[0]}))))
        else $error("pad output does not follow route select");

    drive_value_a: assert property (
        route_reg[0][0] == 1'b0 && $stable(drive_reg[0][0]) |=>
        o_pad_out[0] == $past(drive_reg[0][0]))
        else $error("software drive value not on pad");

    pullup_sel_a: assert property (
        ##1 o_pad_pullup[PAD_W-1:0] ==
        ($past(drive_reg[0]) & ~$past(dir_reg[0])))
        else $error("pull-up select wrong");

    analog_block_a: assert property (
        ##1 (level[PAD_W-1:0] & $past(analog_reg)) == '0)
        else $error("disabled input still reads high");

    change_sets_a: assert property (
        grp_evt[0] |=> sts_reg[0])
        else $error("enabled change did not set status");

    only_enabled_a: assert property (
        $rose(sts_reg[0]) |-> $past(grp_evt[0]) &&
        |$past(chg_en_reg[0]))
        else $error("status set without enabled change");

    readback_data_a: assert property (
        i_rd && hit_rb_a |=> o_rdata[PAD_W-1:0] == $past(level[PAD_W-1:0]))
        else $error("readback data wrong");

    read_clears_a: assert property (
        i_rd && hit_rb_a && (|chg_en_reg[0]) && !grp_evt[0] |=> !sts_reg[0])
        else $error("readback read did not clear status");

    reset_default_a: assert property (
        @(posedge i_core_clk) disable iff (1'b0)
        !i_rstn |=> dir_reg[0] == '0 && route_reg[0] == '0 &&
        analog_reg == '0 && sts_reg == '0 && irq_en_reg == '0)
        else $error("register not at default after reset");

    change_cause_a: assert property (
        $changed(level[PAD_W-1:0]) |-> |change[PAD_W-1:0])
        else $error("level change not detected");

    irq_level_a: assert property (
        grp_evt[0] && irq_en_reg[0] && !wr_irq_en |=> o_irq)
        else $error("enabled change did not raise interrupt");

    cover_irq_c: cover property (grp_evt[0] ##1 o_irq);
    cover_rb_clear_c: cover property (rb_clr[0] && sts_reg[0]);
    cover_periph_c: cover property (route_reg[1] != '0 && dir_reg[1] != '0);
    cover_collide_c: cover property (grp_evt[2] && sw_clr[2]);

endmodule

/* File: hdl/gpc_pad_group.sv */
`timescale 1ns/1ps
// Output path, pull-up select and level change detection of one pad group
module gpc_pad_group
    import gpc_pkg::*;
#(
    parameter int PAD_W = GPC_PAD_W
)
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Synchronised pad levels
    input wire logic [PAD_W-1:0] i_pad_sync,
    // Configuration from the register file
    input wire logic [PAD_W-1:0] i_dir,
    input wire logic [PAD_W-1:0] i_route,
    input wire logic [PAD_W-1:0] i_drive,
    input wire logic [PAD_W-1:0] i_in_dis,
    // Peripheral output levels
    input wire logic [PAD_W-1:0] i_periph,
    // Pad controls
    output logic [PAD_W-1:0] o_pad_out,
    output logic [PAD_W-1:0] o_pad_oe,
    output logic [PAD_W-1:0] o_pullup,
    // Sampled levels and change pulses
    output logic [PAD_W-1:0] o_level,
    output logic [PAD_W-1:0] o_change
);

    logic [PAD_W-1:0] out_reg;
    logic [PAD_W-1:0] oe_reg;
    logic [PAD_W-1:0] pu_reg;
    logic [PAD_W-1:0] lvl_reg;
    logic [PAD_W-1:0] prev_reg;
    // Selected drive value and gated input
    wire [PAD_W-1:0] out_next;
    wire [PAD_W-1:0] pu_next;
    wire [PAD_W-1:0] lvl_next;

    // Peripheral or software value per pad
    assign out_next = (i_route & i_periph) | (~i_route & i_drive);
    // Drive bit doubles as pull-up select while input
    assign pu_next = ~i_dir & i_drive;
    // Disabled input path reads as low and never toggles
    assign lvl_next = i_pad_sync & ~i_in_dis;

    // Registered pad controls and level samples
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
        begin
            out_reg <= '0;
            oe_reg <= '0;
            pu_reg <= '0;
            lvl_reg <= '0;
            prev_reg <= '0;
        end
        else
        begin
            out_reg <= out_next;
            oe_reg <= i_dir;
            pu_reg <= pu_next;
            lvl_reg <= lvl_next;
            prev_reg <= lvl_reg;
        end
    end

    assign o_pad_out = out_reg;
    assign o_pad_oe = oe_reg;
    assign o_pullup = pu_reg;
    assign o_level = lvl_reg;
    // Current sample against the one of the previous cycle
    assign o_change = lvl_reg ^ prev_reg;

endmodule

/* File: hdl/gpc_pkg.sv */
// Shared constants of the pad control block
package gpc_pkg;

    // Pads per group and number of pad groups (A, B, C)
    localparam int GPC_PAD_W = 8;
    localparam int GPC_GROUPS = 3;

    // Register bus widths
    localparam int GPC_ADDR_W = 8;
    localparam int GPC_DATA_W = 32;

    // Group base addresses; each group owns a 32-byte window
    localparam logic [7:0] GPC_GRP_A_BASE = 8'h00;
    localparam logic [7:0] GPC_GRP_B_BASE = 8'h20;
    localparam logic [7:0] GPC_GRP_C_BASE = 8'h40;
    localparam logic [7:0] GPC_IRQ_BASE = 8'h60;

    // Register offsets inside a pad group window
    localparam logic [4:0] GPC_DIR_OFS = 5'h00;
    localparam logic [4:0] GPC_ROUTE_OFS = 5'h04;
    localparam logic [4:0] GPC_DRIVE_OFS = 5'h08;
    localparam logic [4:0] GPC_CHG_EN_OFS = 5'h0c;
    localparam logic [4:0] GPC_READBACK_OFS = 5'h10;
    localparam logic [4:0] GPC_ANALOG_OFS = 5'h14;

    // Register offsets inside the interrupt window
    localparam logic [4:0] GPC_IRQ_STS_OFS = 5'h00;
    localparam logic [4:0] GPC_IRQ_EN_OFS = 5'h04;
    localparam logic [4:0] GPC_IRQ_CLR_OFS = 5'h08;

    // Reset value of every control and configuration register
    localparam logic [7:0] GPC_RST_VAL = 8'h00;

endpackage

/* File: hdl/gpc_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous pad levels
module gpc_sync
    import gpc_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    // First stage is read only by the second stage
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // Both stages clear on reset
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule

/* File: verification/gpc_pad_ctrl_test.sv */
`timescale 1ns/1ps
// Register-level bench of the pad control block
module gpc_pad_ctrl_test;
    import gpc_pkg::*;

    // Stimulus and observed signals
    logic i_core_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic [23:0] pad_level, o_pad_out, o_pad_oe, o_pad_pullup;
    logic [7:0] o_pad_a_input_en;
    logic [23:0] i_periph_out = 24'h0;
    logic [23:0] ext_val = 24'h0;
    logic [23:0] ext_en = 24'hffffff;
    logic o_irq;
    int fail_count = 0;
    int checked = 0;

    // 125 MHz clock
    always #4 i_core_clk = ~i_core_clk;

    gpc_pad_ctrl u_gpc_pad_ctrl (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_pad_in(pad_level), .o_pad_out(o_pad_out),
        .o_pad_oe(o_pad_oe), .o_pad_pullup(o_pad_pullup),
        .o_pad_a_input_en(o_pad_a_input_en), .i_periph_out(i_periph_out),
        .o_irq(o_irq));

    gpc_pad_model u_gpc_pad_model (.i_core_clk(i_core_clk),
        .i_pad_out(o_pad_out), .i_pad_oe(o_pad_oe),
        .i_pad_pullup(o_pad_pullup), .i_ext_val(ext_val),
        .i_ext_en(ext_en), .o_level(pad_level));

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask

    // Pad edge needs three edges to read back, one more for status
    task automatic settle();
        repeat (6) @(posedge i_core_clk);
        #1;
    endtask

    // Single exit point of the run
    task automatic finish_test();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog: the sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge i_core_clk);
        fail_count++;
        finish_test();
    end

    // Main sequence
    initial
    begin
        logic [7:0] b;
        repeat (16) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        #1 chk(o_pad_oe, 0);
        chk(o_pad_a_input_en, 8'hff);
        // Every configuration register starts cleared
        for (int g = 0; g < 3; g++)
            for (int o = 0; o < 5; o++)
                rd(8'(g * 32 + o * 4), 0);
        rd(8'h14, 0);
        rd(8'h64, 0);
        // A change on pad 0 of each group, then clear by readback read
        for (int g = 0; g < 3; g++)
        begin
            b = 8'(g * 32);
            wr(b + 8'h0c, 32'h1);
            wr(8'h64, 32'h7);
            ext_val[g * 8] <= 1'b1;
            settle();
            rd(8'h60, 32'(1 << g));
            chk(o_irq, 1);
            rd(b + 8'h10, 32'h1);
            rd(8'h60, 0);
            chk(o_irq, 0);
        end
        // Pad without its enable bit raises nothing
        ext_val[1] <= 1'b1;
        settle();
        rd(8'h60, 0);
        // Status is sticky while masked; clear register drops it
        ext_val[0] <= 1'b0;
        wr(8'h64, 32'h0);
        settle();
        chk(o_irq, 0);
        rd(8'h60, 32'h1);
        wr(8'h68, 32'h1);
        rd(8'h60, 0);
        // Group A as outputs: low nibble from peripheral, high from drive
        i_periph_out <= 24'h00003c;
        wr(8'h08, 32'ha5);
        wr(8'h04, 32'h0f);
        wr(8'h00, 32'hff);
        settle();
        chk(o_pad_oe[7:0], 8'hff);
        chk(o_pad_out[7:0], 8'hac);
        rd(8'h10, 32'hac);
        // Analog disable masks the digital input of the low nibble
        wr(8'h14, 32'h0f);
        settle();
        chk(o_pad_a_input_en, 8'hf0);
        rd(8'h10, 32'ha0);
        // Group B inputs: drive bit selects the pull-up
        ext_en[15:8] <= 8'h00;
        wr(8'h28, 32'h5a);
        settle();
        chk(o_pad_pullup[15:8], 8'h5a);
        chk(o_pad_oe[15:8], 0);
        rd(8'h7c, 0);
        // Reset in mid-run restores defaults
        @(posedge i_core_clk);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        #1 chk(o_pad_oe, 0);
        rd(8'h00, 0);
        rd(8'h28, 0);
        finish_test();
    end
endmodule

/* File: verification/gpc_pad_model.sv */
`timescale 1ns/1ps
// Pads and the circuitry on them, as seen from the pins
module gpc_pad_model
(
    // Clock
    input wire logic i_core_clk,
    // Pad controls from the block
    input wire logic [23:0] i_pad_out,
    input wire logic [23:0] i_pad_oe,
    input wire logic [23:0] i_pad_pullup,
    // External drivers set by the bench
    input wire logic [23:0] i_ext_val,
    input wire logic [23:0] i_ext_en,
    // Resolved pad levels
    output logic [23:0] o_level
);
    // Toggles every cycle so a floating pad never reads as a steady value
    logic float_reg = 1'b0;

    // Free-running toggle
    always @(posedge i_core_clk)
    begin
        float_reg <= ~float_reg;
    end

    // Block drive wins, then the outside driver, then the pull-up
    always_comb
    begin
        for (int i = 0; i < 24; i++)
        begin
            if (i_pad_oe[i])
                o_level[i] = i_pad_out[i];
            else if (i_ext_en[i])
                o_level[i] = i_ext_val[i];
            else if (i_pad_pullup[i])
                o_level[i] = 1'b1;
            else
                o_level[i] = float_reg ^ i[0];
        end
    end
endmodule
